/* common/mfs_pkg.sv */
// Constants and carrier types for the motion and frame statistics registers.
// Assumes one 250 MHz clock and a register port already decoded from the
// serial link into read and write strobes.
package mfs_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_MOTION = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_X_LOW = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_Y_LOW = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_XY_HIGH = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_QUALITY = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_EXPO_UPPER = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_EXPO_LOWER = 7'h08;
  localparam logic [ADDR_W-1:0] ADDR_PEAK = 7'h09;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int DISP_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int STEP_W = 8;
  localparam int FEAT_W = 9;
  localparam int EXPO_W = 16;
  localparam int MOVE_BIT = 7;
  localparam int OVERFLOW_BIT = 4;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [DISP_W-1:0] DISP_RST = 12'h000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] QUALITY_RST = 8'h00;
  localparam logic [BYTE_W-1:0] PEAK_RST = 8'hD0;
  localparam logic [EXPO_W-1:0] EXPO_RST = 16'h0064;
  localparam logic [BYTE_W-1:0] QUALITY_MAX = 8'hF2;
  localparam logic [BYTE_W-1:0] PEAK_MAX = 8'hFE;

  // ----------------------------------------
  // Exposure regulation targets
  // ----------------------------------------
  localparam logic [EXPO_W-1:0] EXPO_MIN = 16'h0010;
  localparam logic [EXPO_W-1:0] EXPO_MAX = 16'h4000;
  localparam logic [EXPO_W-1:0] EXPO_STEP = 16'h0004;
  localparam logic [BYTE_W-1:0] PEAK_HI = 8'hE0;
  localparam logic [BYTE_W-1:0] PEAK_LO = 8'h80;
  localparam logic [BYTE_W-1:0] AVG_HI = 8'hA0;
  localparam logic [BYTE_W-1:0] AVG_LO = 8'h40;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Per-frame results from the image pipeline
  typedef struct packed {
    logic valid;
    logic signed [STEP_W-1:0] dx;
    logic signed [STEP_W-1:0] dy;
    logic [FEAT_W-1:0] features;
    logic surface_lost;
    logic [BYTE_W-1:0] peak;
    logic [BYTE_W-1:0] avg;
  } mfs_frame_type;

  // Register access strobe from the serial port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } mfs_req_type;

endpackage

/* logic/mfs_exposure_ctrl.sv */
// Automatic exposure regulation, one adjustment per frame.
// Assumes frame results arrive as a single-cycle valid with the frame's
// peak and average pixel values.
module mfs_exposure_ctrl (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire mfs_pkg::mfs_frame_type frame,
  output logic [mfs_pkg::EXPO_W-1:0] exposure
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [mfs_pkg::EXPO_W-1:0] expo;
  } mfs_expo_state_type;

  mfs_expo_state_type state_q;
  mfs_expo_state_type state_d;

  // Too bright shortens, too dark lengthens, clamped to the window
  always_comb
  begin
    state_d = state_q;
    if (frame.valid)
    begin
      if (frame.peak > mfs_pkg::PEAK_HI || frame.avg > mfs_pkg::AVG_HI)
      begin
        if (state_q.expo > mfs_pkg::EXPO_MIN + mfs_pkg::EXPO_STEP)
          state_d.expo = state_q.expo - mfs_pkg::EXPO_STEP;
        else
          state_d.expo = mfs_pkg::EXPO_MIN;
      end
      else if (frame.peak < mfs_pkg::PEAK_LO && frame.avg < mfs_pkg::AVG_LO)
      begin
        if (state_q.expo < mfs_pkg::EXPO_MAX - mfs_pkg::EXPO_STEP)
          state_d.expo = state_q.expo + mfs_pkg::EXPO_STEP;
        else
          state_d.expo = mfs_pkg::EXPO_MAX;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= '{expo: mfs_pkg::EXPO_RST};
    else
      state_q <= state_d;
  end

  assign exposure = state_q.expo;

endmodule

/* logic/mfs_regs.sv */
// Motion, surface quality, exposure and peak pixel register group.
// Assumes the serial port delivers single-cycle read and write strobes with
// an address, and the image pipeline a single-cycle frame result.
// Frame steps are signed and already limited to one byte per axis.

// Operation
// - Horizontal low byte shows displacement bits 7..0; reading it clears it.
// - Vertical low byte shows displacement bits 7..0; reading it clears it.
// - High byte: X bits 11..8 in 7..4, Y bits 11..8 in 3..0.
// - Reading the high byte clears the reported displacement; live sums gathered during the readout carry over.
// - Surface quality is the upper eight bits of the nine-bit feature count.
// - Surface quality never reads above 242.
// - Surface quality is near zero with no surface below.
// - Exposure is sixteen bits of clock cycles, split over two registers.
// - Exposure adjusts itself to keep average and peak pixel in range.
// - Peak pixel reports the frame maximum, 0 to 254, per frame.
// - Any write to motion status clears flags and all displacement.
// - Accumulator overflow sets a flag and freezes accumulation until the high byte is read.
// - Motion flag shows displacement is waiting since the last report.
module mfs_regs (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire mfs_pkg::mfs_req_type req,
  input wire mfs_pkg::mfs_frame_type frame,
  output logic [mfs_pkg::BYTE_W-1:0] rd_data,
  output logic rd_valid,
  output logic movement_flag,
  output logic accumulator_overflow_flag
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    // Live sums of frame steps
    logic [mfs_pkg::DISP_W-1:0] acc_x;
    logic [mfs_pkg::DISP_W-1:0] acc_y;
    // Snapshot taken when a readout opens
    logic [mfs_pkg::DISP_W-1:0] snap_x;
    logic [mfs_pkg::DISP_W-1:0] snap_y;
    // Readout and status flags
    logic held;
    logic moved;
    logic overflow;
    // Per-frame statistics and exposure latch
    logic [mfs_pkg::BYTE_W-1:0] quality;
    logic [mfs_pkg::BYTE_W-1:0] peak;
    logic [mfs_pkg::BYTE_W-1:0] expo_lo;
    // Registered read answer
    logic [mfs_pkg::BYTE_W-1:0] rdata;
    logic rvalid;
  } mfs_state_type;

  localparam mfs_state_type STATE_RST = '{
    acc_x: mfs_pkg::DISP_RST,
    acc_y: mfs_pkg::DISP_RST,
    snap_x: mfs_pkg::DISP_RST,
    snap_y: mfs_pkg::DISP_RST,
    held: 1'b0,
    moved: 1'b0,
    overflow: 1'b0,
    quality: mfs_pkg::QUALITY_RST,
    peak: mfs_pkg::PEAK_RST,
    expo_lo: mfs_pkg::EXPO_RST[mfs_pkg::BYTE_W-1:0],
    rdata: mfs_pkg::BYTE_ZERO,
    rvalid: 1'b0
  };

  mfs_state_type state_q;
  mfs_state_type state_d;
  logic [mfs_pkg::EXPO_W-1:0] exposure;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Signed add of a frame step; top bit flags a 12-bit overflow
  function automatic logic [mfs_pkg::DISP_W:0] acc_add(
    input logic [mfs_pkg::DISP_W-1:0] acc,
    input logic [mfs_pkg::STEP_W-1:0] step
  );
    logic [mfs_pkg::DISP_W:0] sum;
    sum = {acc[mfs_pkg::DISP_W-1], acc}
        + {{(mfs_pkg::DISP_W-mfs_pkg::STEP_W+1){step[mfs_pkg::STEP_W-1]}}, step};
    return {sum[mfs_pkg::DISP_W] ^ sum[mfs_pkg::DISP_W-1], sum[mfs_pkg::DISP_W-1:0]};
  endfunction

  // Clamp a byte to a ceiling
  function automatic logic [mfs_pkg::BYTE_W-1:0] clamp8(
    input logic [mfs_pkg::BYTE_W-1:0] value,
    input logic [mfs_pkg::BYTE_W-1:0] ceiling
  );
    return (value > ceiling) ? ceiling : value;
  endfunction

  // Status byte: movement and overflow bits, the rest read zero
  function automatic logic [mfs_pkg::BYTE_W-1:0] status_byte(
    input logic moved,
    input logic overflow
  );
    logic [mfs_pkg::BYTE_W-1:0] value;
    value = mfs_pkg::BYTE_ZERO;
    value[mfs_pkg::MOVE_BIT] = moved;
    value[mfs_pkg::OVERFLOW_BIT] = overflow;
    return value;
  endfunction

  // Shared high byte: X top nibble above Y top nibble
  function automatic logic [mfs_pkg::BYTE_W-1:0] high_nibbles(
    input logic [mfs_pkg::DISP_W-1:0] x,
    input logic [mfs_pkg::DISP_W-1:0] y
  );
    return {x[mfs_pkg::DISP_W-1:mfs_pkg::BYTE_W], y[mfs_pkg::DISP_W-1:mfs_pkg::BYTE_W]};
  endfunction

  // ----------------------------------------
  // Exposure regulator
  // ----------------------------------------
  // Adjusts once per frame; its upper byte is read live below, the lower byte latched
  mfs_exposure_ctrl u_exposure (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .frame(frame),
    .exposure(exposure)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic rd_motion;
  logic rd_x_low;
  logic rd_y_low;
  logic rd_high;
  logic rd_quality;
  logic rd_expo_up;
  logic rd_expo_lo;
  logic rd_peak;
  logic wr_motion;
  logic frame_moved;
  logic [mfs_pkg::DISP_W-1:0] view_x;
  logic [mfs_pkg::DISP_W-1:0] view_y;
  logic [mfs_pkg::DISP_W:0] sum_x;
  logic [mfs_pkg::DISP_W:0] sum_y;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // One-hot read strobes from the access address
  always_comb
  begin
    rd_motion = 1'b0;
    rd_x_low = 1'b0;
    rd_y_low = 1'b0;
    rd_high = 1'b0;
    rd_quality = 1'b0;
    rd_expo_up = 1'b0;
    rd_expo_lo = 1'b0;
    rd_peak = 1'b0;
    wr_motion = req.wr && req.addr == mfs_pkg::ADDR_MOTION;
    if (!req.rd)
      rd_motion = 1'b0;
    else if (req.addr == mfs_pkg::ADDR_MOTION)
      rd_motion = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_X_LOW)
      rd_x_low = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_Y_LOW)
      rd_y_low = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_XY_HIGH)
      rd_high = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_QUALITY)
      rd_quality = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_EXPO_UPPER)
      rd_expo_up = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_EXPO_LOWER)
      rd_expo_lo = 1'b1;
    else if (req.addr == mfs_pkg::ADDR_PEAK)
      rd_peak = 1'b1;
  end

  // Report view: held snapshot if a readout is open, else live sums
  assign view_x = state_q.held ? state_q.snap_x : state_q.acc_x;
  assign view_y = state_q.held ? state_q.snap_y : state_q.acc_y;
  assign frame_moved = frame.valid && (frame.dx != '0 || frame.dy != '0);

  // Readout, clearing and accumulation
  always_comb
  begin
    state_d = state_q;
    state_d.rvalid = req.rd;
    sum_x = '0;
    sum_y = '0;
    // First read of the readout freezes a snapshot, live sums restart
    // Frames landing during the readout go to the live sums only
    if ((rd_motion || rd_x_low || rd_y_low) && !state_q.held)
    begin
      state_d.snap_x = state_q.acc_x;
      state_d.snap_y = state_q.acc_y;
      state_d.held = 1'b1;
      state_d.acc_x = mfs_pkg::DISP_RST;
      state_d.acc_y = mfs_pkg::DISP_RST;
    end
    if (rd_x_low)
      state_d.snap_x[mfs_pkg::BYTE_W-1:0] = mfs_pkg::BYTE_ZERO;
    if (rd_y_low)
      state_d.snap_y[mfs_pkg::BYTE_W-1:0] = mfs_pkg::BYTE_ZERO;
    // High byte read ends the readout and releases the overflow freeze
    // Nonzero live sums gathered while the readout was open keep the flag up
    if (rd_high)
    begin
      state_d.snap_x = mfs_pkg::DISP_RST;
      state_d.snap_y = mfs_pkg::DISP_RST;
      state_d.held = 1'b0;
      state_d.overflow = 1'b0;
      if (!state_q.held)
      begin
        state_d.acc_x = mfs_pkg::DISP_RST;
        state_d.acc_y = mfs_pkg::DISP_RST;
      end
      state_d.moved = state_q.held && (state_q.acc_x != '0 || state_q.acc_y != '0);
    end
    // Any write to motion status wipes flags and displacement
    // Write data is never stored; only the address matters
    if (wr_motion)
    begin
      state_d.acc_x = mfs_pkg::DISP_RST;
      state_d.acc_y = mfs_pkg::DISP_RST;
      state_d.snap_x = mfs_pkg::DISP_RST;
      state_d.snap_y = mfs_pkg::DISP_RST;
      state_d.held = 1'b0;
      state_d.moved = 1'b0;
      state_d.overflow = 1'b0;
    end
    // Frame step lands after clears, so a same-cycle event is kept
    // A step that would overflow either axis is dropped whole
    if (frame.valid && !state_d.overflow)
    begin
      sum_x = acc_add(state_d.acc_x, frame.dx);
      sum_y = acc_add(state_d.acc_y, frame.dy);
      if (sum_x[mfs_pkg::DISP_W] || sum_y[mfs_pkg::DISP_W])
        state_d.overflow = 1'b1;
      else
      begin
        state_d.acc_x = sum_x[mfs_pkg::DISP_W-1:0];
        state_d.acc_y = sum_y[mfs_pkg::DISP_W-1:0];
      end
    end
    if (frame_moved)
      state_d.moved = 1'b1;
    // Per-frame statistics
    if (frame.valid)
    begin
      if (frame.surface_lost)
        state_d.quality = mfs_pkg::QUALITY_RST;
      else
        state_d.quality = clamp8(frame.features[mfs_pkg::FEAT_W-1:1],
                                 mfs_pkg::QUALITY_MAX);
      state_d.peak = clamp8(frame.peak, mfs_pkg::PEAK_MAX);
    end
    // Upper exposure read pins the lower half
    // A later upper read re-latches, so the pair is read back to back
    if (rd_expo_up)
      state_d.expo_lo = exposure[mfs_pkg::BYTE_W-1:0];
    // Read data mux, unmapped addresses answer zero
    state_d.rdata = mfs_pkg::BYTE_ZERO;
    if (rd_motion)
      state_d.rdata = status_byte(state_q.moved, state_q.overflow);
    else if (rd_x_low)
      state_d.rdata = view_x[mfs_pkg::BYTE_W-1:0];
    else if (rd_y_low)
      state_d.rdata = view_y[mfs_pkg::BYTE_W-1:0];
    else if (rd_high)
      state_d.rdata = high_nibbles(view_x, view_y);
    else if (rd_quality)
      state_d.rdata = state_q.quality;
    else if (rd_expo_up)
      state_d.rdata = exposure[mfs_pkg::EXPO_W-1:mfs_pkg::BYTE_W];
    else if (rd_expo_lo)
      state_d.rdata = state_q.expo_lo;
    else if (rd_peak)
      state_d.rdata = state_q.peak;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= STATE_RST;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data = state_q.rdata;
  assign rd_valid = state_q.rvalid;
  assign movement_flag = state_q.moved;
  assign accumulator_overflow_flag = state_q.overflow;

endmodule

/* testbench/mfs_regs_monitor.sv */
// Checker for the motion and frame statistics register group.
// Assumes it is bound to mfs_regs and sees only that module's ports.
module mfs_regs_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire mfs_pkg::mfs_req_type req,
  input wire mfs_pkg::mfs_frame_type frame,
  input wire logic [mfs_pkg::BYTE_W-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic movement_flag,
  input wire logic accumulator_overflow_flag
);
  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic wr_stat;
  logic clr_overflow;
  // Status write and readout close
  assign wr_stat = req.wr && req.addr == mfs_pkg::ADDR_MOTION;
  assign clr_overflow = wr_stat || (req.rd && req.addr == mfs_pkg::ADDR_XY_HIGH);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_read_gets_answer: assert property (req.rd |=> rd_valid)
    else $error("read without answer");
  a_no_stray_answer: assert property (!req.rd |=> !rd_valid)
    else $error("answer without read");
  a_idle_data_zero: assert property (!rd_valid |-> rd_data == 8'h00)
    else $error("read data not zero when idle");
  a_write_clears_flags: assert property (wr_stat && !frame.valid |=>
    !movement_flag && !accumulator_overflow_flag)
    else $error("status write left a flag set");
  a_quality_ceiling: assert property (req.rd && req.addr == mfs_pkg::ADDR_QUALITY |=>
    rd_data <= mfs_pkg::QUALITY_MAX)
    else $error("surface quality above ceiling");
  a_peak_ceiling: assert property (req.rd && req.addr == mfs_pkg::ADDR_PEAK |=>
    rd_data <= mfs_pkg::PEAK_MAX)
    else $error("peak pixel above ceiling");
  a_motion_sets_flag: assert property (frame.valid && frame.dx != 8'h00 |=>
    movement_flag || accumulator_overflow_flag)
    else $error("motion left flag clear");
  a_overflow_holds: assert property (accumulator_overflow_flag && !clr_overflow |=>
    accumulator_overflow_flag)
    else $error("overflow dropped before readout");

  // Main scenarios reached
  c_quality_read: cover property (req.rd && req.addr == mfs_pkg::ADDR_QUALITY);
  c_overflow: cover property ($rose(accumulator_overflow_flag));
  c_status_write: cover property (wr_stat ##1 !movement_flag);
endmodule

bind mfs_regs mfs_regs_monitor mon (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .req(req),
  .frame(frame),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .movement_flag(movement_flag),
  .accumulator_overflow_flag(accumulator_overflow_flag)
);

/* testbench/mfs_host_model.sv */
// Host controller model issuing register reads and writes.
// Assumes requests are taken on the rising edge and answered one cycle later.
module mfs_host_model (
  input wire logic sys_clk,
  input wire logic [mfs_pkg::BYTE_W-1:0] rd_data,
  input wire logic rd_valid,
  output mfs_pkg::mfs_req_type req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus with junk address and data
  initial req = '{1'b0, 1'b0, 7'h55, 8'hAA};

  // One read, strobe for one edge, answer taken after it
  task automatic rd(input logic [6:0] a, output logic [8:0] d);
    @(negedge sys_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    req.addr = ~a;
    d = {rd_valid, rd_data};
  endtask

  // One write, data not kept afterwards
  task automatic wr(input logic [6:0] a, input logic [7:0] w);
    @(negedge sys_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = w;
    @(negedge sys_clk);
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~w;
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the motion and frame statistics registers.
// Assumes mfs_regs with its bound checker and the host model beside it.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic resetn;
  mfs_pkg::mfs_req_type req;
  mfs_pkg::mfs_frame_type frame;
  logic [7:0] rd_data;
  logic rd_valid;
  logic movement_flag;
  logic accumulator_overflow_flag;
  logic [8:0] got;
  int fail_count;
  int n_tests;
  int cycles;

  mfs_regs uut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .req(req),
    .frame(frame),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .movement_flag(movement_flag),
    .accumulator_overflow_flag(accumulator_overflow_flag)
  );

  mfs_host_model host (
    .sys_clk(sys_clk),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .req(req)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Cut a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Read with answer flag expected high
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk(got, {1'b1, e});
  endtask

  // One frame result; mid-range pixels keep exposure still
  task automatic frm(input logic [7:0] dx, dy, input logic [8:0] ft, input logic lost,
    input logic [7:0] pk, av);
    @(negedge sys_clk);
    frame = '{1'b1, dx, dy, ft, lost, pk, av};
    @(negedge sys_clk);
    frame.valid = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'hD0};
    for (int i = 0; i < 8; i++)
      rc(7'(i + 2), e[i]);
    $display("t_reset done");
  endtask

  task automatic t_motion();
    frm(8'h05, 8'hFD, 9'h000, 1'b0, 8'hA0, 8'h50);
    frm(8'hF9, 8'h02, 9'h000, 1'b0, 8'hA0, 8'h50);
    rc(7'h02, 8'h80);
    rc(7'h03, 8'hFE);
    rc(7'h04, 8'hFF);
    rc(7'h05, 8'hFF);
    rc(7'h05, 8'h00);
    rc(7'h02, 8'h00);
    $display("t_motion done");
  endtask

  task automatic t_lowclr();
    // Close the readout that the last status read opened
    rc(7'h05, 8'h00);
    frm(8'h03, 8'h04, 9'h000, 1'b0, 8'hA0, 8'h50);
    rc(7'h03, 8'h03);
    rc(7'h03, 8'h00);
    rc(7'h04, 8'h04);
    rc(7'h04, 8'h00);
    rc(7'h05, 8'h00);
    $display("t_lowclr done");
  endtask

  task automatic t_wrclr();
    frm(8'h09, 8'h00, 9'h000, 1'b0, 8'hA0, 8'h50);
    host.wr(7'h02, 8'h5A);
    rc(7'h02, 8'h00);
    rc(7'h03, 8'h00);
    rc(7'h05, 8'h00);
    $display("t_wrclr done");
  endtask

  task automatic t_ovf();
    for (int i = 0; i < 18; i++)
      frm(8'h7F, 8'h00, 9'h000, 1'b0, 8'hA0, 8'h50);
    chk({7'h00, movement_flag, accumulator_overflow_flag}, 9'h003);
    rc(7'h02, 8'h90);
    rc(7'h03, 8'hF0);
    rc(7'h04, 8'h00);
    rc(7'h05, 8'h70);
    rc(7'h02, 8'h00);
    $display("t_ovf done");
  endtask

  task automatic t_quality();
    frm(8'h00, 8'h00, 9'h1FF, 1'b0, 8'hA0, 8'h50);
    rc(7'h06, 8'hF2);
    host.wr(7'h06, 8'h11);
    rc(7'h06, 8'hF2);
    frm(8'h00, 8'h00, 9'h0A5, 1'b0, 8'hA0, 8'h50);
    rc(7'h06, 8'h52);
    frm(8'h00, 8'h00, 9'h1FF, 1'b1, 8'hA0, 8'h50);
    rc(7'h06, 8'h00);
    rc(7'h0A, 8'h00);
    $display("t_quality done");
  endtask

  task automatic t_expo();
    frm(8'h00, 8'h00, 9'h000, 1'b0, 8'hFF, 8'h50);
    rc(7'h09, 8'hFE);
    rc(7'h07, 8'h00);
    rc(7'h08, 8'h60);
    frm(8'h00, 8'h00, 9'h000, 1'b0, 8'h20, 8'h10);
    rc(7'h09, 8'h20);
    rc(7'h08, 8'h60);
    rc(7'h07, 8'h00);
    rc(7'h08, 8'h64);
    $display("t_expo done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    resetn = 1'b0;
    frame = '0;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    t_reset();
    t_motion();
    t_lowclr();
    t_wrclr();
    t_ovf();
    t_quality();
    t_expo();
    final_report();
  end
endmodule
